// *** src/dtt_pkg.sv ***
// Package: constants, types and field layouts of the termination timing block
//==============================================================================
// Overview of operation
// - Synchronous timing when DLL on and locked and a termination value is enabled.
// - Synchronous in active, refresh, idle, active power-down, and kept-DLL precharge power-down.
// - Synchronous: termination follows pin sampled high or low after a latency.
// - Turn-on and turn-off latency both equal CAS write plus additive latency minus two.
// - Internal termination control is delayed by the programmed additive latency.
// - Turn-off completes half a link clock, plus or minus 0.2, after latency ends.
// - Asynchronous timing in DLL-off precharge power-down and while DLL resynchronises.
// - Asynchronous mode ignores additive latency and uses fixed analog delays.
// - Asynchronous turn-on 2 to 8.5 ns, turn-off within 8.5 ns.
// - Dynamic termination is active when either write termination code bit is set.
// - Dynamic: switch nominal to write termination write latency minus two after write.
// - Switch back four or six clocks plus turn-off latency after chop-4 or burst-8.
package dtt_pkg;

    //==========================================================================
    // Register map (byte addresses)
    localparam logic [3:0]  CTRL_ADDR   = 4'h0;
    localparam logic [3:0]  STATUS_ADDR = 4'h4;
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 32;

    // Control register layout, bit 0 upward: dll_on, dll_locked, dll_pd_keep,
    // al_code[1:0], nom_code[2:0], wr_code[1:0], cwl[3:0], cl[3:0], bank_active
    typedef struct packed {
        logic       bank_active;
        logic [3:0] cl;
        logic [3:0] cas_write_latency;
        logic [1:0] wr_code;
        logic [2:0] nom_code;
        logic [1:0] al_code;
        logic       dll_pd_keep;
        logic       dll_locked;
        logic       dll_on;
    } dtt_cfg_s;

    localparam int CFG_W = $bits(dtt_cfg_s);

    localparam dtt_cfg_s CFG_RST = '{
        bank_active : 1'b0,
        cl          : 4'h6,
        cas_write_latency         : 4'h5,
        wr_code     : 2'h0,
        nom_code    : 3'h0,
        al_code     : 2'h0,
        dll_pd_keep : 1'b0,
        dll_locked  : 1'b0,
        dll_on      : 1'b1
    };

    // Additive latency codes
    localparam logic [1:0] AL_ZERO     = 2'h0;
    localparam logic [1:0] AL_CL_M1    = 2'h1;
    localparam logic [1:0] AL_CL_M2    = 2'h2;

    // Status register layout
    localparam int ST_TERM_LSB   = 0;
    localparam int ST_SYNC_BIT   = 3;
    localparam int ST_ACTIVE_BIT = 4;

    //==========================================================================
    // Termination state, one-hot
    typedef enum logic [2:0] {
        TERM_OFF = 3'b001,
        TERM_NOM = 3'b010,
        TERM_WR  = 3'b100
    } dtt_term_e;

    // Pins sampled from the link, after synchronisation
    typedef struct packed {
        logic ck;
        logic cke;
        logic odt;
        logic wr;
        logic bc4;
    } dtt_link_s;

    localparam int LINK_W = $bits(dtt_link_s);

    // What travels down the latency line per link edge
    typedef struct packed {
        logic odt;
        logic wr;
        logic bc4;
    } dtt_pipe_s;

    localparam int PIPE_W = $bits(dtt_pipe_s);

    //==========================================================================
    // Timing
    localparam int          CLK_PERIOD_PS    = 100000;
    localparam int          ASYNC_ON_MIN_PS  = 2000;
    localparam int          ASYNC_OFF_MAX_PS = 8500;
    localparam logic [2:0]  HOLD_SHORT_TCK   = 3'h4;
    localparam logic [2:0]  HOLD_LONG_TCK    = 3'h6;
    localparam logic [4:0]  LAT_OFFSET_TCK   = 5'h2;
    localparam int          MAX_LAT_TCK      = 32;

    // Least time rounds up, longest rounds down, never under one cycle
    localparam int ASYNC_ON_CYC_RAW  = (ASYNC_ON_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_OFF_CYC_RAW = ASYNC_OFF_MAX_PS / CLK_PERIOD_PS;
    localparam logic [1:0] ASYNC_ON_CYC  = 2'(ASYNC_ON_CYC_RAW < 1 ? 1 : ASYNC_ON_CYC_RAW);
    localparam logic [1:0] ASYNC_OFF_CYC = 2'(ASYNC_OFF_CYC_RAW < 1 ? 1 : ASYNC_OFF_CYC_RAW);

endpackage

// *** src/dtt_sync2.sv ***
// Two-stage synchroniser for pins arriving from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module dtt_sync2
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } dtt_sync_s;

    dtt_sync_s s;
    dtt_sync_s next_s;

    always_comb
    begin
        next_s.meta = din;
        next_s.sync = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign dout = s.sync;
endmodule
`default_nettype wire

// *** src/dtt_delay_line.sv ***
// Shift line advanced once per link edge, read at a programmable tap
`timescale 1ns/1ps
`default_nettype none
module dtt_delay_line
#(
    parameter int W     = 3,
    parameter int DEPTH = 32
)
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     shift,
    input  wire logic [W-1:0]             din,
    input  wire logic [$clog2(DEPTH)-1:0] tap,
    output logic      [W-1:0]             dout
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] stage;
    } dtt_line_s;

    dtt_line_s s;
    dtt_line_s next_s;

    always_comb
    begin
        next_s = s;
        if (shift)
        begin
            next_s.stage[0] = din;
            for (int i = 1; i < DEPTH; i++)
                next_s.stage[i] = s.stage[i-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign dout = s.stage[tap];
endmodule
`default_nettype wire

// *** src/dtt_term_ctrl.sv ***
// On-die termination timing controller with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module dtt_term_ctrl
    import dtt_pkg::*;
#(
    parameter int LINK_PERIOD_NS = 800,
    parameter int MAX_LAT        = MAX_LAT_TCK
)
(
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [DATA_W-1:0] AVS_WRITEDATA,
    output logic      [DATA_W-1:0] AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    input  wire logic              LINK_CK,
    input  wire logic              LINK_CKE,
    input  wire logic              TERM_PIN,
    input  wire logic              WRITE_CMD,
    input  wire logic              BURST_CHOP,
    output logic      [2:0]        TERM_STATE,
    output logic                   TERM_ACTIVE,
    output logic                   SYNC_MODE
);
    //==========================================================================
    // Derived timing
    localparam int LINK_PERIOD_PS = LINK_PERIOD_NS * 1000;
    // Half a link clock in core cycles; the 0.2 clock tolerance covers rounding
    localparam int OFF_SKEW_RAW = LINK_PERIOD_PS / (2 * CLK_PERIOD_PS);
    localparam logic [7:0] OFF_SKEW_CYC = 8'(OFF_SKEW_RAW < 1 ? 1 : OFF_SKEW_RAW);
    localparam int TAP_W = $clog2(MAX_LAT);

    //==========================================================================
    // State
    typedef struct packed {
        logic              wreq;
        logic [DATA_W-1:0] rdata;
        dtt_cfg_s          cfg;
        logic              ck_prev;
        logic [2:0]        wr_cnt;
        dtt_term_e         term;
        logic              active;
        logic [7:0]        off_cnt;
        logic [1:0]        async_cnt;
        logic              sync_mode;
    } dtt_state_s;

    dtt_state_s s;
    dtt_state_s next_s;

    dtt_link_s  lk;
    dtt_pipe_s  dl;
    dtt_pipe_s  pipe_in;
    logic       ck_rise;
    logic [4:0] al_val;
    logic [4:0] wl_val;
    logic [TAP_W-1:0] tap;

    //==========================================================================
    // Pin capture
    dtt_sync2 #(.W(LINK_W)) u_sync
    (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .din   ({LINK_CK, LINK_CKE, TERM_PIN, WRITE_CMD, BURST_CHOP}),
        .dout  (lk)
    );

    assign ck_rise = lk.ck & ~s.ck_prev;

    //==========================================================================
    // Latency derivation
    always_comb
    begin
        case (s.cfg.al_code)
            AL_CL_M1: al_val = 5'(s.cfg.cl) - 5'h1;
            AL_CL_M2: al_val = 5'(s.cfg.cl) - 5'h2;
            default:  al_val = 5'h0;
        endcase
        wl_val = 5'(s.cfg.cas_write_latency) + al_val;
        // Line output is one edge late, so the tap is one short of the latency
        if (wl_val > LAT_OFFSET_TCK + 5'h1)
            tap = TAP_W'(wl_val - LAT_OFFSET_TCK - 5'h1);
        else
            tap = '0;
    end

    assign pipe_in = '{odt: lk.odt, wr: lk.wr & lk.odt, bc4: lk.bc4};

    dtt_delay_line #(.W(PIPE_W), .DEPTH(MAX_LAT)) u_line
    (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .shift (ck_rise),
        .din   (pipe_in),
        .tap   (tap),
        .dout  (dl)
    );

    //==========================================================================
    // Next state
    logic nom_en;
    logic dyn_en;
    logic any_en;
    logic pre_pd;
    logic sync_ok;
    dtt_term_e on_term;
    dtt_term_e async_target;

    always_comb
    begin
        nom_en  = (s.cfg.nom_code != 3'h0);
        dyn_en  = (s.cfg.wr_code != 2'h0);
        any_en  = nom_en | dyn_en;
        pre_pd  = ~lk.cke & ~s.cfg.bank_active;
        // Precharge power-down only forces async when the DLL is let go
        sync_ok = s.cfg.dll_on & s.cfg.dll_locked & any_en
                & ~(pre_pd & ~s.cfg.dll_pd_keep);

        next_s           = s;
        next_s.ck_prev   = lk.ck;
        next_s.sync_mode = sync_ok;

        // Bus slave: one wait cycle, then the transfer completes
        next_s.wreq = ~((AVS_READ | AVS_WRITE) & s.wreq);
        if ((AVS_READ | AVS_WRITE) & s.wreq)
        begin
            case (AVS_ADDRESS)
                CTRL_ADDR:
                    next_s.rdata = DATA_W'(s.cfg);
                STATUS_ADDR:
                begin
                    next_s.rdata = '0;
                    next_s.rdata[ST_TERM_LSB +: 3] = s.term;
                    next_s.rdata[ST_SYNC_BIT]      = s.sync_mode;
                    next_s.rdata[ST_ACTIVE_BIT]    = s.active;
                end
                default:
                    next_s.rdata = '0;
            endcase
        end
        if (AVS_WRITE & ~s.wreq & (AVS_ADDRESS == CTRL_ADDR))
            next_s.cfg = dtt_cfg_s'(AVS_WRITEDATA[CFG_W-1:0]);

        on_term      = TERM_OFF;
        async_target = TERM_OFF;

        if (sync_ok)
        begin
            next_s.async_cnt = 2'h0;
            if (ck_rise)
            begin
                // Write window is opened by a delayed write and counts link edges
                if (dl.wr & dyn_en)
                    next_s.wr_cnt = dl.bc4 ? HOLD_SHORT_TCK : HOLD_LONG_TCK;
                else if (s.wr_cnt != 3'h0)
                    next_s.wr_cnt = s.wr_cnt - 3'h1;

                if (dyn_en & (dl.wr | (s.wr_cnt > 3'h1)))
                    on_term = TERM_WR;
                else if (nom_en)
                    on_term = TERM_NOM;
                else
                    on_term = TERM_OFF;
                next_s.term = dl.odt ? on_term : TERM_OFF;
            end
        end
        else
        begin
            // Pin acts directly; no latency, no dynamic switching
            next_s.wr_cnt = 3'h0;
            async_target  = (lk.odt & nom_en) ? TERM_NOM : TERM_OFF;
            if (async_target == s.term)
                next_s.async_cnt = 2'h0;
            else if (s.async_cnt + 2'h1 >=
                     ((async_target == TERM_OFF) ? ASYNC_OFF_CYC : ASYNC_ON_CYC))
            begin
                next_s.term      = async_target;
                next_s.async_cnt = 2'h0;
            end
            else
                next_s.async_cnt = s.async_cnt + 2'h1;
        end

        // Physical termination enable; sync turn-off lags by half a link clock
        if (next_s.term != TERM_OFF)
        begin
            next_s.active  = 1'b1;
            next_s.off_cnt = 8'h0;
        end
        else if (!sync_ok)
        begin
            next_s.active  = 1'b0;
            next_s.off_cnt = 8'h0;
        end
        else if (s.term != TERM_OFF)
            next_s.off_cnt = OFF_SKEW_CYC;
        else if (s.off_cnt > 8'h1)
            next_s.off_cnt = s.off_cnt - 8'h1;
        else if (s.off_cnt == 8'h1)
        begin
            next_s.active  = 1'b0;
            next_s.off_cnt = 8'h0;
        end
    end

    //==========================================================================
    // Registers
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s           <= '0;
            s.wreq      <= 1'b1;
            s.cfg       <= CFG_RST;
            s.term      <= TERM_OFF;
        end
        else
            s <= next_s;
    end

    assign AVS_READDATA    = s.rdata;
    assign AVS_WAITREQUEST = s.wreq;
    assign TERM_STATE      = s.term;
    assign TERM_ACTIVE     = s.active;
    assign SYNC_MODE       = s.sync_mode;
endmodule
`default_nettype wire

// *** verification/dtt_ctl.sv ***
// Controller-side model that drives the link pins of the termination block
`timescale 1ns/1ps
`default_nettype none
module dtt_ctl
(
    output var logic ck,
    output var logic cke,
    output var logic odt,
    output var logic wr,
    output var logic bc4
);
    // Link clock runs free, phase unrelated to the core clock
    initial
    begin
        ck = 1'b0;
        cke = 1'b1;
        odt = 1'b0;
        wr = 1'b0;
        bc4 = 1'b0;
        #37;
        forever #400 ck = ~ck;
    end

    task automatic set_cke(input logic v);
        @(negedge ck);
        cke <= v;
    endtask

    // Pins move on the falling edge so every rising edge sees a settled level
    task automatic burst(input int h, input bit w, input bit c);
        int n;
        n = (h < 4) ? 4 : h;
        if (w && n < (c ? 4 : 6))
            n = c ? 4 : 6;
        @(negedge ck);
        odt <= 1'b1;
        wr <= w;
        bc4 <= c;
        @(negedge ck);
        wr <= 1'b0;
        repeat (n - 1) @(negedge ck);
        // Pin goes low between bursts, which leaves room for read gaps
        odt <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/dtt_term_ctrl_assertions.sv ***
// Checker for the termination timing block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module dtt_chk
    import dtt_pkg::*;
#(
    parameter int LINK_PERIOD_NS = 800
)
(
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic       TERM_PIN,
    input wire logic [2:0] TERM_STATE,
    input wire logic       TERM_ACTIVE,
    input wire logic       SYNC_MODE
);
    localparam int CPL = LINK_PERIOD_NS / 100;
    logic [7:0] wr_run;

    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    // Length of the current write-termination stretch in core cycles
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            wr_run <= 8'h0;
        else
            wr_run <= (TERM_STATE == TERM_WR) ? wr_run + 8'h1 : 8'h0;
    end

    //==========================================================================
    // Properties
    property p_onehot;
        $onehot(TERM_STATE);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("termination state not one-hot");
    property p_reset;
        $rose(RST_N) |-> TERM_STATE == TERM_OFF && !TERM_ACTIVE && !SYNC_MODE;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs wrong after reset release");
    property p_active;
        TERM_STATE != TERM_OFF |-> TERM_ACTIVE;
    endproperty
    a_active: assert property (p_active)
        else $error("termination chosen but not applied");
    property p_off_skew;
        SYNC_MODE && TERM_STATE == TERM_OFF && $past(TERM_STATE) != TERM_OFF
            |-> TERM_ACTIVE [*4] ##1 !TERM_ACTIVE;
    endproperty
    a_off_skew: assert property (p_off_skew)
        else $error("turn-off skew not half a link clock");
    property p_cadence;
        SYNC_MODE && $changed(TERM_STATE) |=> ($stable(TERM_STATE) || !SYNC_MODE) [*6];
    endproperty
    a_cadence: assert property (p_cadence)
        else $error("state changed between link edges");
    property p_async_drop;
        (!SYNC_MODE) [*6] ##0 TERM_STATE == TERM_OFF |-> !TERM_ACTIVE;
    endproperty
    a_async_drop: assert property (p_async_drop)
        else $error("async turn-off delayed");
    property p_async_on;
        (!SYNC_MODE) [*8] ##0 $rose(TERM_ACTIVE) |-> $past(TERM_PIN, 2) && TERM_PIN;
    endproperty
    a_async_on: assert property (p_async_on)
        else $error("async turn-on without pin");
    property p_async_off;
        (!SYNC_MODE) [*8] ##0 $fell(TERM_PIN) |-> ##[1:12] TERM_STATE == TERM_OFF;
    endproperty
    a_async_off: assert property (p_async_off)
        else $error("async turn-off too late");
    property p_wr_len;
        SYNC_MODE && $past(TERM_STATE) == TERM_WR && TERM_STATE != TERM_WR
            |-> wr_run inside {[4*CPL-1:4*CPL+1], [6*CPL-1:6*CPL+1]};
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("write termination window wrong length");

    c_wr: cover property (TERM_STATE == TERM_WR);
    c_async: cover property (!SYNC_MODE && TERM_STATE == TERM_NOM);
    c_sync_off: cover property (SYNC_MODE && $fell(TERM_ACTIVE));
endmodule

bind dtt_term_ctrl dtt_chk #(.LINK_PERIOD_NS(LINK_PERIOD_NS)) i_dtt_chk
(
    .CORE_CLK    (CORE_CLK),
    .RST_N       (RST_N),
    .TERM_PIN    (TERM_PIN),
    .TERM_STATE  (TERM_STATE),
    .TERM_ACTIVE (TERM_ACTIVE),
    .SYNC_MODE   (SYNC_MODE)
);
`default_nettype wire

// *** verification/dtt_term_ctrl_tb.sv ***
// Self-checking testbench for the termination timing block
`timescale 1ns/1ps
`default_nettype none
module dtt_term_ctrl_tb
    import dtt_pkg::*;
;
    logic              CORE_CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic [ADDR_W-1:0] AVS_ADDRESS;
    logic [DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA, rdat;
    logic              LINK_CK, LINK_CKE, TERM_PIN, WRITE_CMD, BURST_CHOP;
    logic [2:0]        TERM_STATE;
    logic              TERM_ACTIVE, SYNC_MODE;
    int                n_mismatch, comparisons, lat;
    // Bits: expected sync, locked, keep DLL, nominal, write, bank active, CKE
    logic [6:0]        modes [7] = '{7'h69, 7'h21, 7'h65, 7'h6a, 7'h78, 7'h28, 7'h09};

    dtt_term_ctrl i_dtt_term_ctrl
    (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .LINK_CK(LINK_CK), .LINK_CKE(LINK_CKE), .TERM_PIN(TERM_PIN),
        .WRITE_CMD(WRITE_CMD), .BURST_CHOP(BURST_CHOP), .TERM_STATE(TERM_STATE),
        .TERM_ACTIVE(TERM_ACTIVE), .SYNC_MODE(SYNC_MODE)
    );
    dtt_ctl i_dtt_ctl
    (
        .ck(LINK_CK), .cke(LINK_CKE), .odt(TERM_PIN), .wr(WRITE_CMD), .bc4(BURST_CHOP)
    );

    always #50 CORE_CLK = ~CORE_CLK;

    //==========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus transfer; held until waitrequest is sampled low
    task automatic bus(input bit we, input logic [3:0] a, input logic [31:0] d);
        int t;
        @(posedge CORE_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= we;
        AVS_READ <= !we;
        AVS_WRITEDATA <= d;
        t = 0;
        do
        begin
            @(posedge CORE_CLK);
            t++;
        end
        while (AVS_WAITREQUEST !== 1'b0 && t < 50);
        rdat = AVS_READDATA;
        chk(32'(AVS_WAITREQUEST), 32'h0);
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    task automatic setcfg(input logic lk, kp, input logic [1:0] al, input logic nm, wc, bk);
        dtt_cfg_s c;
        c = CFG_RST;
        c.dll_locked = lk;
        c.dll_pd_keep = kp;
        c.al_code = al;
        c.nom_code = {2'h0, nm};
        c.wr_code = {1'b0, wc};
        c.bank_active = bk;
        bus(1'b1, CTRL_ADDR, 32'(c));
        bus(1'b0, CTRL_ADDR, 32'h0);
        chk(rdat, 32'(c));
        repeat (3) @(posedge LINK_CK);
    endtask

    function automatic logic [2:0] exp_st(int k, n, l, bit w, c, nom, wre);
        if (k < l || k > n - 1 + l)
            return TERM_OFF;
        if (w && wre && k < l + (c ? 4 : 6))
            return TERM_WR;
        return nom ? TERM_NOM : TERM_OFF;
    endfunction

    // Pin burst from the model while the state is checked once per link edge
    task automatic run(input int h, input bit w, c, input int l, input bit nom, wre);
        fork
            i_dtt_ctl.burst(h, w, c);
            begin
                @(negedge LINK_CK);
                @(posedge LINK_CK);
                for (int k = 0; k <= h + l + 1; k++)
                begin
                    repeat (5) @(posedge CORE_CLK);
                    @(negedge CORE_CLK);
                    chk(32'(TERM_STATE), 32'(exp_st(k, h, l, w, c, nom, wre)));
                    @(posedge LINK_CK);
                end
            end
        join
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    //==========================================================================
    // Sequence
    initial
    begin
        #2_000_000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        CORE_CLK = 1'b0;
        RST_N = 1'b0;
        AVS_ADDRESS = '0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = '0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (16) @(posedge CORE_CLK);
        chk({TERM_ACTIVE, SYNC_MODE, TERM_STATE}, {2'b00, TERM_OFF});
        RST_N <= 1'b1;
        bus(1'b0, CTRL_ADDR, 32'h0);
        chk(rdat, 32'(CFG_RST));
        bus(1'b0, 4'h8, 32'h0);
        chk(rdat, 32'h0);
        bus(1'b1, STATUS_ADDR, 32'hffff_ffff);
        bus(1'b0, STATUS_ADDR, 32'h0);
        chk(rdat, 32'(TERM_OFF));
        foreach (modes[i])
        begin
            setcfg(modes[i][5], modes[i][4], AL_ZERO, modes[i][3], modes[i][2], modes[i][1]);
            i_dtt_ctl.set_cke(modes[i][0]);
            repeat (4) @(posedge LINK_CK);
            bus(1'b0, STATUS_ADDR, 32'h0);
            chk(32'(rdat[ST_SYNC_BIT]), 32'(modes[i][6]));
        end
        i_dtt_ctl.set_cke(1'b1);
        for (int a = 0; a < 3; a++)
        begin
            setcfg(1'b1, 1'b0, 2'(a), 1'b1, 1'b0, 1'b0);
            lat = 32'(CFG_RST.cas_write_latency) + ((a == 0) ? 0 : 32'(CFG_RST.cl) - a) - 2;
            run(4, 1'b0, 1'b0, lat, 1'b1, 1'b0);
        end
        for (int j = 0; j < 3; j++)
        begin
            setcfg(1'b1, 1'b0, AL_ZERO, j < 2, 1'b1, 1'b0);
            run(8, 1'b1, j == 0, 3, j < 2, 1'b1);
        end
        setcfg(1'b0, 1'b0, AL_CL_M1, 1'b1, 1'b0, 1'b0);
        run(4, 1'b0, 1'b0, 0, 1'b1, 1'b0);
        setcfg(1'b1, 1'b0, AL_ZERO, 1'b1, 1'b0, 1'b0);
        i_dtt_ctl.set_cke(1'b0);
        repeat (4) @(posedge LINK_CK);
        run(5, 1'b0, 1'b0, 0, 1'b1, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
